// ### ppw_cpu_model.sv
// Purpose: CPU side of the far call and return page path
// Assumes: Requests are one cycle pulses, never both at once
// Notes: Saved page lives here, as in the CPU stack
`timescale 1ns/1ns
module ppw_cpu_model (
  input wire logic clk_sys,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic [5:0] target,
  input wire logic [5:0] far_rdata,
  output logic far_wr,
  output logic [5:0] far_wdata
);
  logic [5:0] saved_r;
  always_ff @(posedge clk_sys)
  begin
    if (call_req)
      saved_r <= far_rdata;
  end
  // Off the address bus entirely
  assign far_wr = call_req | ret_req;
  assign far_wdata = call_req ? target : saved_r;
endmodule

// ### ppw_defs.svh
// Purpose: Constants for the program page window mapper
// Assumes: Included by bare name
// Notes: Offsets are byte addresses on the plain register port
`ifndef PPW_DEFS_SVH
`define PPW_DEFS_SVH
`define PPW_OFS_PAGE 8'h30
`define PPW_OFS_CFG 8'h31
`define PPW_OFS_STAT 8'h32
`define PPW_RST_PAGE_OPEN 6'h00
`define PPW_RST_PAGE_LOCK 6'h3C
`define PPW_WIN_LO 16'h8000
`define PPW_WIN_HI 16'hBFFF
`define PPW_WIN_OFS_W 14
`define PPW_SPLIT_128K 2'h0
`define PPW_SPLIT_256K 2'h1
`define PPW_SPLIT_512K 2'h2
`define PPW_SPLIT_ALL 2'h3
`define PPW_INT_BASE_128K 6'h38
`define PPW_INT_BASE_256K 6'h30
`define PPW_INT_BASE_512K 6'h20
`endif

// ### ppw_pkg.sv
// Purpose: Types for the program page window mapper
// Assumes: Nothing
// Notes: Constants live in ppw_defs.svh
package ppw_pkg;
  typedef logic [5:0] ppw_page_t;
  typedef logic [19:0] ppw_ext_addr_t;
  typedef enum logic [1:0] {PPW_IDLE, PPW_FAR_HOLD} ppw_far_e;
endpackage

// ### ppw_route.sv
// Purpose: Window decode, internal/external split, extended address
// Assumes: Purely combinational
// Notes: Split switches are static at integration
`timescale 1ns/1ns
`include "ppw_defs.svh"
module ppw_route (
  input wire logic [15:0] cpu_addr,
  input wire ppw_pkg::ppw_page_t page,
  input wire logic [1:0] paging_split_switches,
  output logic in_window,
  output logic internal,
  output ppw_pkg::ppw_ext_addr_t ext_addr
);
  function automatic logic page_internal(input logic [5:0] p, input logic [1:0] sw);
    logic r;
    r = 1'b1;
    case (sw)
      `PPW_SPLIT_128K: r = (p >= `PPW_INT_BASE_128K);
      `PPW_SPLIT_256K: r = (p >= `PPW_INT_BASE_256K);
      `PPW_SPLIT_512K: r = (p >= `PPW_INT_BASE_512K);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  always_comb
  begin
    in_window = (cpu_addr >= `PPW_WIN_LO) && (cpu_addr <= `PPW_WIN_HI);
    internal = page_internal(page, paging_split_switches);
    ext_addr = {page, cpu_addr[`PPW_WIN_OFS_W-1:0]};
  end
endmodule

// ### ppw_strap.sv
// Purpose: Catch the ROM control strap after reset release
// Assumes: Strap stable around reset release
// Notes: Async reset loads a constant; strap taken on first edge after
`timescale 1ns/1ns
module ppw_strap (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rom_control_strap,
  input wire logic emul_mode,
  input wire logic expanded_mode,
  output logic rom_enable_bit
);
  logic done_r;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      done_r <= 1'b0;
      rom_enable_bit <= 1'b0;
    end
    else if (!done_r)
    begin
      done_r <= 1'b1;
      // Emulation with strap high, or expanded with strap low, maps ROM off-chip
      if (emul_mode)
        rom_enable_bit <= !rom_control_strap;
      else if (expanded_mode)
        rom_enable_bit <= rom_control_strap;
      else
        rom_enable_bit <= 1'b1;
    end
  end
endmodule

// ### ppw_top.sv
// Purpose: Program page window mapper with page index register
// Assumes: Single clock, plain register port, CPU far path synchronous
// Notes: Far path wins over a bus write in the same cycle
// Summary of operation
// - Paged space extends 64K CPU space up to 1M bytes.
// - Accesses in 0x8000..0xBFFF go to the selected 16K page.
// - Six index bits choose one of 64 pages.
// - Bus write to page index takes effect one cycle later.
// - Far call and return reach page index via dedicated path.
// - Dedicated path update completes before instruction ends.
// - Reset 0x00 writable always, or 0x3C writable in special modes.
// - Two-bit switch sets on-chip share: 128K, 256K, 512K, all.
// - Internal when page in upper range for switch; otherwise external.
// - Strap captured into ROM enable at reset release: inverted in emulation, as is in expanded mode; else set to 1.
// - Strap high in emulation or low in expanded clears ROM enable.
`timescale 1ns/1ns
`include "ppw_defs.svh"
module ppw_top #(
  parameter bit LOCKED_INDEX = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic special_mode,
  input wire logic emul_mode,
  input wire logic expanded_mode,
  input wire logic rom_control_strap,
  input wire logic [1:0] paging_split_switches,
  input wire logic far_wr,
  input wire logic [5:0] far_wdata,
  output logic [5:0] far_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_valid,
  output logic win_hit,
  output logic win_internal,
  output logic win_external,
  output logic [19:0] win_ext_addr,
  output logic rom_enable_bit
);
  ppw_pkg::ppw_page_t program_page_index_r;
  ppw_pkg::ppw_page_t page_nxt;
  logic bus_wr_ok;
  logic in_window;
  logic internal;
  ppw_pkg::ppw_ext_addr_t ext_addr;
  logic [1:0] far_count_r;

  // Locked variant permits bus writes only in special modes
  assign bus_wr_ok = reg_wr && (reg_addr == `PPW_OFS_PAGE) &&
                     (!LOCKED_INDEX || special_mode);

  always_comb
  begin
    page_nxt = program_page_index_r;
    if (far_wr)
      page_nxt = far_wdata;
    else if (bus_wr_ok)
      page_nxt = reg_wdata[5:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      program_page_index_r <= LOCKED_INDEX ? `PPW_RST_PAGE_LOCK : `PPW_RST_PAGE_OPEN;
    else
      program_page_index_r <= page_nxt;
  end

  // Dedicated path never touches the register port
  assign far_rdata = program_page_index_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      far_count_r <= 2'h0;
    else if (far_wr && far_count_r != 2'h3)
      far_count_r <= far_count_r + 2'h1;
  end

  ppw_route u_route (
    .cpu_addr(cpu_addr),
    .page(program_page_index_r),
    .paging_split_switches(paging_split_switches),
    .in_window(in_window),
    .internal(internal),
    .ext_addr(ext_addr)
  );

  ppw_strap u_strap (
    .clk_sys(clk_sys),
    .rst(rst),
    .rom_control_strap(rom_control_strap),
    .emul_mode(emul_mode),
    .expanded_mode(expanded_mode),
    .rom_enable_bit(rom_enable_bit)
  );

  // Registered window outputs: one cycle after the CPU address
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      win_hit <= 1'b0;
      win_internal <= 1'b0;
      win_external <= 1'b0;
      win_ext_addr <= 20'h00000;
    end
    else
    begin
      win_hit <= cpu_valid && in_window;
      win_internal <= cpu_valid && in_window && internal;
      win_external <= cpu_valid && in_window && !internal;
      win_ext_addr <= ext_addr;
    end
  end

  // Register read port; unmapped reads return zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `PPW_OFS_PAGE)
        reg_rdata <= {2'h0, program_page_index_r};
      else if (reg_addr == `PPW_OFS_CFG)
        reg_rdata <= {5'h00, LOCKED_INDEX, paging_split_switches};
      else if (reg_addr == `PPW_OFS_STAT)
        reg_rdata <= {7'h00, rom_enable_bit};
      else
        reg_rdata <= 8'h00;
    end
    else
      reg_rdata <= 8'h00;
  end

  a_bus_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
    bus_wr_ok && !far_wr |=> program_page_index_r == $past(reg_wdata[5:0]))
    else $error("page index bus write not applied");
  a_far_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
    far_wr |=> far_rdata == $past(far_wdata))
    else $error("far path write not applied");
  a_locked_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    (LOCKED_INDEX && !special_mode && reg_wr && !far_wr) |=> $stable(program_page_index_r))
    else $error("locked page index changed");
  a_window_addr_form: assert property (@(posedge clk_sys) disable iff (rst)
    cpu_valid && in_window |=> win_ext_addr == {$past(program_page_index_r), $past(cpu_addr[13:0])})
    else $error("extended address wrong");
  a_window_range: assert property (@(posedge clk_sys) disable iff (rst)
    win_hit |-> $past(cpu_addr[15:14]) == 2'h2)
    else $error("window hit outside range");
  a_split_all_int: assert property (@(posedge clk_sys) disable iff (rst)
    win_hit && $past(paging_split_switches) == 2'h3 |-> win_internal)
    else $error("full on-chip split went external");
  a_split_128k: assert property (@(posedge clk_sys) disable iff (rst)
    win_hit && $past(paging_split_switches) == 2'h0 |->
    win_internal == ($past(program_page_index_r) >= 6'h38))
    else $error("128K split decode wrong");
  a_read_page_data: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == `PPW_OFS_PAGE && !far_wr && !reg_wr |=>
    reg_rdata == {2'h0, program_page_index_r})
    else $error("page index readback wrong");
  a_int_ext_excl: assert property (@(posedge clk_sys) disable iff (rst)
    !(win_internal && win_external))
    else $error("internal and external together");
  c_far_write: cover property (@(posedge clk_sys) disable iff (rst) far_wr);
  c_bus_write: cover property (@(posedge clk_sys) disable iff (rst) bus_wr_ok);
  c_ext_access: cover property (@(posedge clk_sys) disable iff (rst) win_external);
  c_far_twice: cover property (@(posedge clk_sys) disable iff (rst) far_count_r == 2'h2);
endmodule

// ### tb_ppw_top.sv
// Purpose: Self-checking bench for the page window mapper
// Assumes: Unlocked index register variant
// Notes: Expected results queued by the driver, popped by the monitor
`timescale 1ns/1ns
module tb_ppw_top;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, cpu_valid = 0;
  logic special_mode = 0, emul_mode = 0, expanded_mode = 0, rom_control_strap = 0;
  logic call_req = 0, ret_req = 0, far_wr, win_hit, win_internal, win_external;
  logic rom_enable_bit, rb, rd_p = 0, win_p = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [1:0] paging_split_switches = 0;
  logic [5:0] target = 0, far_wdata, far_rdata, pg, sv;
  logic [15:0] cpu_addr = 0;
  logic [19:0] win_ext_addr;
  logic [22:0] wq[$];
  logic [7:0] rq[$];
  logic [2:0] rt[5] = '{3'h0, 3'h5, 3'h4, 3'h2, 3'h3};
  logic [5:0] pt[8] = '{6'h1F, 6'h20, 6'h2F, 6'h30, 6'h37, 6'h38, 6'h3F, 6'h00};
  integer errors = 0, total_checks = 0, seed = 32'hc286f548, i, j;
  ppw_top u_ppw_top (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .special_mode, .emul_mode, .expanded_mode, .rom_control_strap,
    .paging_split_switches, .far_wr, .far_wdata, .far_rdata, .cpu_addr,
    .cpu_valid, .win_hit, .win_internal, .win_external, .win_ext_addr,
    .rom_enable_bit);
  ppw_cpu_model u_ppw_cpu_model (.clk_sys, .call_req, .ret_req, .target,
    .far_rdata, .far_wr, .far_wdata);
  always #25 clk_sys = ~clk_sys;
  task chk(input string n, input logic [22:0] e, input logic [22:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [22:0] wexp(logic [15:0] a, logic [5:0] p, logic [1:0] s);
    logic h, n;
    h = a >= 16'h8000 && a <= 16'hBFFF;
    n = h && (s == 2'h3 || p >= (s == 2'h0 ? 6'h38 : s == 2'h1 ? 6'h30 : 6'h20));
    return {h, n, h && !n, p, a[13:0]};
  endfunction
  // One bus cycle; the model page moves after expectations are queued
  task cyc(input logic w, r, input logic [7:0] ad, d, input logic v, c, t,
    input logic [15:0] ca);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= d;
    cpu_valid <= v;
    cpu_addr <= ca;
    call_req <= c;
    ret_req <= t;
    target <= d[5:0];
    special_mode <= $random(seed);
    if (r)
      rq.push_back(ad == 8'h30 ? {2'h0, pg} : ad == 8'h31 ?
        {6'h0, paging_split_switches} : ad == 8'h32 ? {7'h0, rb} : 8'h00);
    if (v)
      wq.push_back(wexp(ca, pg, paging_split_switches));
    if (c)
      {sv, pg} = {pg, d[5:0]};
    else if (t)
      pg = sv;
    else if (w && ad == 8'h30)
      pg = d[5:0];
    @(posedge clk_sys);
  endtask
  task rst_with(input logic [2:0] m);
    // Drop strobes and let pending results be checked before reset clears them
    reg_wr <= 0;
    reg_rd <= 0;
    cpu_valid <= 0;
    call_req <= 0;
    ret_req <= 0;
    @(negedge clk_sys);
    rst <= 1;
    {emul_mode, expanded_mode, rom_control_strap} <= m;
    rb = m[2] ? !m[0] : m[1] ? m[0] : 1'b1;
    pg = 6'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    #1 chk("rom_enable_bit", rb, rom_enable_bit);
  endtask
  always @(posedge clk_sys)
  begin
    rd_p <= reg_rd;
    win_p <= cpu_valid;
  end
  always @(negedge clk_sys)
  begin
    if (rd_p)
      chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (win_p)
      chk("window", wq.pop_front(), {win_hit, win_internal, win_external, win_ext_addr});
  end
  initial
  begin
    for (i = 0; i < 5; i++)
    begin
      rst_with(rt[i]);
      cyc(0, 1, 8'h32, 0, 0, 0, 0, 0);
      cyc(0, 1, 8'h30, 0, 1, 0, 0, 16'h8000);
    end
    // Boundary pages against every split setting
    for (i = 0; i < 4; i++)
    begin
      paging_split_switches <= i[1:0];
      // Idle cycle so queued expectations see the new split setting
      cyc(0, 0, 0, 0, 0, 0, 0, 0);
      cyc(0, 1, 8'h31, 0, 0, 0, 0, 0);
      for (j = 0; j < 8; j++)
      begin
        cyc(1, 0, 8'h30, {2'h3, pt[j]}, 1, 0, 0, 16'hBFFF);
        cyc(0, 1, 8'h30, 0, 1, 0, 0, 16'h8000 | ($random(seed) & 16'h3FFF));
        cyc(0, 0, 0, 0, 1, 0, 0, $random(seed));
      end
    end
    cyc(0, 0, 0, 0, 1, 0, 0, 16'h7FFF);
    cyc(0, 0, 0, 0, 1, 0, 0, 16'hC000);
    cyc(1, 0, 8'h30, 8'h05, 0, 0, 0, 0);
    cyc(1, 0, 8'h30, 8'h11, 1, 1, 0, 16'h9234);
    cyc(0, 1, 8'h30, 0, 1, 0, 0, 16'hA001);
    cyc(0, 0, 0, 0, 0, 0, 1, 0);
    cyc(1, 0, 8'h31, 8'hFF, 1, 0, 0, 16'h8ABC);
    cyc(0, 1, 8'h31, 0, 0, 0, 0, 0);
    cyc(1, 0, 8'h40, 8'h2A, 0, 0, 0, 0);
    cyc(0, 1, 8'h40, 0, 0, 0, 0, 0);
    cyc(0, 1, 8'h30, 0, 1, 0, 0, 16'hBFFF);
    cyc(0, 0, 0, 0, 0, 0, 0, 0);
    @(posedge clk_sys);
    complete_run;
  end
endmodule
